/* verilog/ltic_ctrl.sv */
`include "ltic_params.svh"
// Operation
// - invalidate clears whole tag entry, LRU too
// - hardware sequencer steps entries in order
// - core keeps running during invalidate
// - writing invalidate bit one starts sequencer
// - in-progress flag high while sequencer runs
// - invalidate takes about 32K core cycles
// - instruction misses not allocated when excluded
// - test push flush writes block into cache
// - test push suppresses block-zero bus broadcast
// - enabled cache serves reads, updates write hits
// - single-beat cacheable: default attributes or translated; translated ones only with first level off or locked
// - first level off means direct lookup
// - test push drops missed single-beat cacheable writes from bus
// - hits and misses reported to monitor
// - invalidate request is control bit ten
// - in-progress flag is read only
// - test push is control bit thirteen
// - instruction exclude is control bit nine
module ltic_ctrl #(
  parameter int INV_CYCLES = `LTIC_INV_CYCLES,
  parameter int IW         = $clog2(INV_CYCLES)
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // core access request
  input  wire logic        accValid,
  input  wire ltic_pkg::ltic_op_t accOp,
  input  wire logic        accIfetch,
  input  wire logic        accSingleBeat,
  input  wire logic        xlateOn,
  input  wire logic [3:0]  pageAttr,
  input  wire logic        l1dEnable,
  input  wire logic        l1dLocked,
  // tag lookup result
  input  wire logic        tagHit,
  // core stall
  output logic             coreStall,
  // decisions toward the cache and system bus
  output logic             lookupEn,
  output logic             allocEn,
  output logic             writeUpdate,
  output logic             flushToCache,
  output logic             l1Invalidate,
  output logic             busFwd,
  // tag array clear port
  output logic             tagClrWe,
  output logic [IW-1:0]    tagClrIdx,
  output logic             tagClrData,
  // performance monitor
  output logic             perfHit,
  output logic             perfMiss
);
  ////////////////////////////////////////////////////////////////////////////
  logic        enFf;
  logic        exclFf;
  logic        invReqFf;
  logic        tpushFf;
  logic        ipFf;
  logic        armedFf;
  logic [31:0] rdataFf;
  logic        ctrlWr;
  logic        invRise;
  ltic_seq_if #(.IW(IW)) sq ();

  // decode shared by read and write paths
  function automatic logic isCtrl(input logic [3:0] a);
    return a == `LTIC_CTRL_OFS;
  endfunction

  assign ctrlWr  = regWr && isCtrl(regAddr);
  assign invRise = ctrlWr && regWdata[`LTIC_INV_BIT] && !invReqFf;

  ////////////////////////////////////////////////////////////////////////////
  // writable control bits
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      enFf     <= 1'(`LTIC_CTRL_RST >> `LTIC_EN_BIT);
      exclFf   <= 1'b0;
      invReqFf <= 1'b0;
      tpushFf  <= 1'b0;
    end
    else if (ctrlWr)
    begin
      enFf     <= regWdata[`LTIC_EN_BIT];
      exclFf   <= regWdata[`LTIC_EXCL_BIT];
      invReqFf <= regWdata[`LTIC_INV_BIT];
      tpushFf  <= regWdata[`LTIC_TPUSH_BIT];
    end
  end

  // re-arm: a new start needs the request bit low first
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      armedFf <= 1'b1;
    else if (invRise && armedFf)
      armedFf <= 1'b0;
    else if (!invReqFf)
      armedFf <= 1'b1;
  end

  assign sq.start = invRise && armedFf && !sq.busy;

  // in-progress flag, set on the same edge as the request bit rises
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      ipFf <= 1'b0;
    else if (sq.start)
      ipFf <= 1'b1;
    // busy without a tag write is the walker's closing cycle, so the flag
    // drops on the same edge as busy and never outlives the walk
    else if (ipFf && sq.busy && !sq.tagWe)
      ipFf <= 1'b0;
  end

  // hardware walker, 2^IW entries, about 32K cycles
  ltic_inv_seq #(.IW(IW)) uSeq (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .sq      (sq)
  );

  // every tag bit written to zero, LRU included
  assign tagClrWe   = sq.tagWe;
  assign tagClrIdx  = sq.tagIdx;
  assign tagClrData = 1'b0;
  // core is never held by the walker
  assign coreStall  = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // read data one cycle later; flag is read only
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdataFf <= 32'h0000_0000;
    else if (regRd && isCtrl(regAddr))
    begin
      rdataFf                  <= 32'h0000_0000;
      rdataFf[`LTIC_EN_BIT]    <= enFf;
      rdataFf[`LTIC_EXCL_BIT]  <= exclFf;
      rdataFf[`LTIC_INV_BIT]   <= invReqFf;
      rdataFf[`LTIC_TPUSH_BIT] <= tpushFf;
      rdataFf[`LTIC_IP_BIT]    <= ipFf;
    end
    else
      rdataFf <= 32'h0000_0000; // unmapped reads answer zero
  end
  assign regRdata = rdataFf;

  ////////////////////////////////////////////////////////////////////////////
  // access classification, combinational for same-cycle steering
  logic cacheableSb;
  logic bypassL1;
  logic isLoad;
  logic isStore;
  logic active;

  assign cacheableSb = accSingleBeat &&
                       ((!xlateOn && pageAttr == `LTIC_DEF_ATTR) ||
                        (xlateOn && !pageAttr[2] && (!l1dEnable || l1dLocked)));
  assign bypassL1    = !l1dEnable || l1dLocked;
  assign active      = accValid && enFf && !ipFf;
  assign isLoad      = accOp == ltic_pkg::LTIC_OP_LOAD;
  assign isStore     = accOp == ltic_pkg::LTIC_OP_STORE;

  // lookup when enabled; a disabled cache never races the walker
  assign lookupEn    = active && (!accIfetch || !exclFf) &&
                       (accIfetch || !cacheableSb || bypassL1);
  assign allocEn     = active && !(accIfetch && exclFf) && !tagHit;
  assign writeUpdate = active && isStore && tagHit;
  assign flushToCache = accValid && tpushFf && l1dEnable &&
                        accOp == ltic_pkg::LTIC_OP_FLUSH;
  assign l1Invalidate = flushToCache;

  // bus forwarding with test-push suppression
  always_comb
  begin
    busFwd = accValid;
    if (tpushFf && accOp == ltic_pkg::LTIC_OP_ZERO)
      busFwd = 1'b0;
    else if (tpushFf && isStore && cacheableSb && !(active && tagHit))
      busFwd = 1'b0;
    else if (flushToCache)
      busFwd = 1'b0;
    else if (active && isLoad && tagHit)
      busFwd = 1'b0;
  end

  // monitor strobes
  assign perfHit  = lookupEn && tagHit;
  assign perfMiss = lookupEn && !tagHit;

  ////////////////////////////////////////////////////////////////////////////
  flag_next_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    sq.start |=> ipFf)
    else $error("in-progress not set after start");
  flag_busy_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ipFf |-> sq.busy)
    else $error("flag set while walker idle");
  clear_run_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    tagClrWe |-> (ipFf && !tagClrData))
    else $error("tag clear outside invalidate");
  zero_bus_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tpushFf && accValid && accOp == ltic_pkg::LTIC_OP_ZERO) |-> !busFwd)
    else $error("block zero broadcast in test push");
  miss_drop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tpushFf && accValid && isStore && cacheableSb && !tagHit) |-> !busFwd)
    else $error("missed write forwarded in test push");
  excl_alloc_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (exclFf && accIfetch) |-> !allocEn)
    else $error("instruction miss allocated");
  perf_pair_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !(perfHit && perfMiss))
    else $error("hit and miss together");
  ip_ro_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ctrlWr && !sq.start && !ipFf) |=> !ipFf)
    else $error("flag written by software");
  no_restart_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ipFf && $fell(ipFf) == 1'b0 && invReqFf) |-> !sq.start)
    else $error("restart without re-arm");

  ////////////////////////////////////////////////////////////////////////////
  // walk length watchdog: the span is far too long for a repetition, so a
  // saturating counter of flag cycles is checked against the entry count
  localparam logic [IW+1:0] IP_MIN = (IW+2)'(INV_CYCLES);
  localparam logic [IW+1:0] IP_MAX = (IW+2)'(INV_CYCLES + 2);
  logic [IW+1:0] ipCntFf;

  // counts flag cycles; saturates so a stuck flag never wraps into range
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      ipCntFf <= '0;
    else if (!ipFf)
      ipCntFf <= '0;
    else if (ipCntFf != {(IW+2){1'b1}})
      ipCntFf <= ipCntFf + 1'b1;
  end

  // flag never stands much longer than one pass over the entries
  walk_max_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ipFf |-> (ipCntFf <= IP_MAX))
    else $error("invalidate ran too long");

  // flag never drops before every entry was visited
  walk_min_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(ipFf) |-> ($past(ipCntFf) >= IP_MIN))
    else $error("invalidate ended too early");

  // flag gone as soon as the walker is idle again
  flag_drop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(sq.busy) |-> !ipFf)
    else $error("flag left set after walk");

  // a start always launches the walker
  walk_start_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    sq.start |=> sq.busy)
    else $error("start did not launch walker");

  // walk begins at the first entry
  idx_first_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    sq.start |=> (tagClrWe && tagClrIdx == '0))
    else $error("walk did not start at entry zero");

  // walk ends after the last entry, no wrap into a second pass
  idx_last_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tagClrWe && tagClrIdx == {IW{1'b1}}) |=> !tagClrWe)
    else $error("walk wrapped past last entry");

  // core never held while the walker runs
  stall_free_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ipFf |-> !coreStall)
    else $error("core stalled by walker");

  // no lookup, allocate or write update competes with the walker; a test-push flush is not held off
  quiet_walk_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ipFf |-> !(lookupEn || allocEn || writeUpdate))
    else $error("cache access during invalidate");

  // a disabled cache does no lookup, allocate or write update; a test-push flush still lands
  lookup_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !enFf |-> !(lookupEn || allocEn || writeUpdate))
    else $error("access while cache disabled");

  // only store hits update contents
  write_upd_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    writeUpdate |-> (isStore && tagHit && enFf))
    else $error("update without store hit");

  // excluded fetches do not even look up
  excl_lookup_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (exclFf && accIfetch) |-> !lookupEn)
    else $error("excluded fetch looked up");

  // test-push flush lands in the cache and drops the first-level copy
  flush_cond_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (accValid && tpushFf && l1dEnable && accOp == ltic_pkg::LTIC_OP_FLUSH) |->
      (flushToCache && l1Invalidate))
    else $error("test push flush not taken");

  // pushed block never reaches the bus
  flush_bus_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    flushToCache |-> !busFwd)
    else $error("pushed block forwarded to bus");

  // untranslated default attributes make an access cacheable
  attr_def_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (accSingleBeat && !xlateOn && pageAttr == `LTIC_DEF_ATTR) |-> cacheableSb)
    else $error("default attributes not cacheable");

  // first level off or locked: direct lookup
  bypass_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (active && !accIfetch && cacheableSb && bypassL1) |-> lookupEn)
    else $error("bypass access not looked up");

  // every lookup reported once to the monitor
  perf_cover_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    lookupEn |-> (perfHit || perfMiss))
    else $error("lookup not reported");

  // request bit follows the write
  inv_wr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ctrlWr |=> (invReqFf == $past(regWdata[`LTIC_INV_BIT])))
    else $error("request bit not written");

  // test-push bit follows the write
  tpush_wr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ctrlWr |=> (tpushFf == $past(regWdata[`LTIC_TPUSH_BIT])))
    else $error("test push bit not written");

  // exclude bit follows the write
  excl_wr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ctrlWr |=> (exclFf == $past(regWdata[`LTIC_EXCL_BIT])))
    else $error("exclude bit not written");

  // read data stands only in the cycle after a read strobe
  rdata_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !$past(regRd) |-> (regRdata == 32'h0000_0000))
    else $error("read data outside answer cycle");
endmodule

/* verilog/ltic_params.svh */
`ifndef LTIC_PARAMS_SVH
`define LTIC_PARAMS_SVH
// control register bit positions
`define LTIC_EN_BIT       0
`define LTIC_EXCL_BIT     9
`define LTIC_INV_BIT      10
`define LTIC_TPUSH_BIT    13
`define LTIC_IP_BIT       31
// register offsets (index addressing, one register)
`define LTIC_CTRL_OFS     4'h0
`define LTIC_STAT_OFS     4'h1
// reset value of the control register
`define LTIC_CTRL_RST     32'h0000_0000
// default page attributes when translation is off
`define LTIC_DEF_ATTR     4'h3
// invalidate length: about 32K core cycles
`define LTIC_INV_CYCLES   32768
`endif

/* verilog/ltic_pkg.sv */
package ltic_pkg;
  typedef enum logic [1:0] {LTIC_IDLE, LTIC_RUN, LTIC_DONE} ltic_state_t;
  typedef enum logic [1:0] {LTIC_OP_LOAD, LTIC_OP_STORE, LTIC_OP_FLUSH, LTIC_OP_ZERO}
    ltic_op_t;
endpackage

/* verilog/ltic_seq_if.sv */
interface ltic_seq_if #(parameter int IW = 15);
  logic          start;
  logic          busy;
  logic          tagWe;
  logic [IW-1:0] tagIdx;
  modport ctrl (output start, input busy, tagWe, tagIdx);
  modport seq  (input start, output busy, tagWe, tagIdx);
endinterface

/* verilog/ltic_inv_seq.sv */
`include "ltic_params.svh"
module ltic_inv_seq #(
  parameter int IW = 15
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // control side
  ltic_seq_if.seq   sq
);
  ltic_pkg::ltic_state_t stateFf;
  ltic_pkg::ltic_state_t nxt_stateFf;
  logic [IW-1:0]         idxFf;
  logic                  lastIdx;

  assign lastIdx = (idxFf == {IW{1'b1}});

  // next state: walk every entry once per start
  always_comb
  begin
    nxt_stateFf = stateFf;
    case (stateFf)
      ltic_pkg::LTIC_IDLE: if (sq.start) nxt_stateFf = ltic_pkg::LTIC_RUN;
      ltic_pkg::LTIC_RUN:  if (lastIdx) nxt_stateFf = ltic_pkg::LTIC_DONE;
      ltic_pkg::LTIC_DONE: nxt_stateFf = ltic_pkg::LTIC_IDLE;
      default:             nxt_stateFf = ltic_pkg::LTIC_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      stateFf <= ltic_pkg::LTIC_IDLE;
    else
      stateFf <= nxt_stateFf;
  end

  // entry index, one entry per cycle, no software per entry
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      idxFf <= '0;
    else if (stateFf == ltic_pkg::LTIC_RUN)
      idxFf <= idxFf + 1'b1;
    else
      idxFf <= '0;
  end

  assign sq.busy   = (stateFf != ltic_pkg::LTIC_IDLE);
  assign sq.tagWe  = (stateFf == ltic_pkg::LTIC_RUN);
  assign sq.tagIdx = idxFf;

  // index moves by exactly one while running
  seq_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (stateFf == ltic_pkg::LTIC_RUN && !lastIdx) |=> (idxFf == $past(idxFf) + 1'b1))
    else $error("invalidate index skipped");
endmodule

/* verif/ltic_tag_model.sv */
module ltic_tag_model #(
  parameter int IW = 4
) (
  // clock
  input  wire logic          sys_clk,
  // clear port
  input  wire logic          tagClrWe,
  input  wire logic [IW-1:0] tagClrIdx,
  input  wire logic          tagClrData,
  // test side
  input  wire logic          fillAll,
  input  wire logic [IW-1:0] lookIdx,
  output logic               tagHit,
  output logic               allClear,
  output logic               inOrder,
  output logic [15:0]        clrCount
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2**IW-1:0] valid_ff;
  logic [IW-1:0]    expIdx_ff;
  logic             inOrder_ff;
  logic [15:0]      clrCnt_ff;
  // tag entries: filled by the bench, cleared one by one by the walker
  always_ff @(posedge sys_clk)
    if (fillAll) valid_ff <= '1;
    else if (tagClrWe) valid_ff[tagClrIdx] <= tagClrData;
  // walk order tracking; any skip or repeat latches a fault
  always_ff @(posedge sys_clk)
    if (fillAll)
    begin
      expIdx_ff  <= '0;
      inOrder_ff <= 1'b1;
      clrCnt_ff  <= 16'h0000;
    end
    else if (tagClrWe)
    begin
      inOrder_ff <= inOrder_ff & (tagClrIdx == expIdx_ff);
      expIdx_ff  <= expIdx_ff + 1'b1;
      clrCnt_ff  <= clrCnt_ff + 16'h0001;
    end
  // lookup answers in the same cycle, as the core expects
  assign tagHit   = valid_ff[lookIdx];
  assign allClear = (valid_ff == '0);
  assign inOrder  = inOrder_ff;
  assign clrCount = clrCnt_ff;
endmodule

/* verif/ltic_ctrl_tb.sv */
module ltic_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int INV = 16;
  localparam int IW  = 4;
  logic sys_clk, sys_rst, regWr, regRd, accValid, accIfetch, accSingleBeat, xlateOn;
  logic l1dEnable, l1dLocked, tagHit, coreStall, lookupEn, allocEn, writeUpdate;
  logic flushToCache, l1Invalidate, busFwd, tagClrWe, tagClrData, perfHit, perfMiss;
  logic fillAll, allClear, inOrder;
  logic [3:0] regAddr, pageAttr;
  logic [31:0] regWdata, regRdata, rv;
  logic [IW-1:0] tagClrIdx;
  logic [15:0] clrCount;
  ltic_pkg::ltic_op_t accOp;
  int mismatches, check_count, n, t0;
  ltic_ctrl #(.INV_CYCLES(INV), .IW(IW)) ltic_ctrl_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .accValid(accValid), .accOp(accOp), .accIfetch(accIfetch), .accSingleBeat(accSingleBeat),
    .xlateOn(xlateOn), .pageAttr(pageAttr), .l1dEnable(l1dEnable), .l1dLocked(l1dLocked),
    .tagHit(tagHit), .coreStall(coreStall), .lookupEn(lookupEn), .allocEn(allocEn),
    .writeUpdate(writeUpdate), .flushToCache(flushToCache), .l1Invalidate(l1Invalidate),
    .busFwd(busFwd), .tagClrWe(tagClrWe), .tagClrIdx(tagClrIdx), .tagClrData(tagClrData),
    .perfHit(perfHit), .perfMiss(perfMiss));
  ltic_tag_model #(.IW(IW)) ltic_tag_model_inst (.sys_clk(sys_clk), .tagClrWe(tagClrWe),
    .tagClrIdx(tagClrIdx), .tagClrData(tagClrData), .fillAll(fillAll), .lookIdx(4'h5),
    .tagHit(tagHit), .allClear(allClear), .inOrder(inOrder), .clrCount(clrCount));
  // 20 MHz core clock
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("mismatches %0d check_count %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // register port: one-cycle strobes, read data in the next cycle only
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  // one core access, decisions sampled once they settle
  task automatic acc(input ltic_pkg::ltic_op_t op, input logic ifx, input logic l1e);
    @(posedge sys_clk);
    accValid  <= 1'b1;
    accOp     <= op;
    accIfetch <= ifx;
    l1dEnable <= l1e;
    #1;
  endtask
  initial
  begin
    {regWr, regRd, accValid, accIfetch, xlateOn, l1dEnable, l1dLocked} = '0;
    {regAddr, regWdata} = '0;
    accOp         = ltic_pkg::LTIC_OP_LOAD;
    accSingleBeat = 1'b1;
    pageAttr      = 4'h3;
    fillAll       = 1'b1;
    sys_rst       = 1'b1;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    fillAll <= 1'b0;
    rd(4'h0, rv); chk("ctrl reset", rv, 32'h0000_0000);
    rd(4'h5, rv); chk("unmapped", rv, 32'h0000_0000);
    // enabled, test push and exclude set, tags all valid
    wr(4'h0, 32'h8000_2201);
    rd(4'h0, rv); chk("ctrl rw", rv, 32'h0000_2201);
    acc(ltic_pkg::LTIC_OP_LOAD, 1'b0, 1'b0);
    chk("lookup", lookupEn, 1'b1);
    chk("hit", {perfHit, perfMiss}, 2'b10);
    acc(ltic_pkg::LTIC_OP_STORE, 1'b0, 1'b0);
    chk("wupd", writeUpdate, 1'b1);
    accValid <= 1'b0;
    // invalidate with the cache disabled
    wr(4'h0, 32'h0000_2200);
    wr(4'h0, 32'h0000_2600);
    t0 = $time;
    rd(4'h0, rv); chk("flag set", rv[31], 1'b1);
    chk("stall", coreStall, 1'b0);
    n = 0;
    while (rv[31] === 1'b1 && n < 40)
    begin
      rd(4'h0, rv);
      n++;
    end
    if (n >= 40)
    begin
      mismatches++;
      end_sim();
    end
    n = ($time - t0) / 50;
    chk("walk len", (n >= INV && n <= INV + 6), 1'b1);
    chk("tags clear", allClear, 1'b1);
    chk("order", {inOrder, clrCount}, {1'b1, 16'(INV)});
    wr(4'h0, 32'h8000_2600);
    rd(4'h0, rv); chk("no restart", rv, 32'h0000_2600);
    chk("clr count", clrCount, 16'(INV));
    wr(4'h0, 32'h0000_2200);
    wr(4'h0, 32'h0000_2201);
    // misses under test push and exclude
    acc(ltic_pkg::LTIC_OP_STORE, 1'b0, 1'b0);
    chk("miss", {perfHit, perfMiss, busFwd}, 3'b010);
    acc(ltic_pkg::LTIC_OP_ZERO, 1'b0, 1'b1);
    chk("zero bus", busFwd, 1'b0);
    acc(ltic_pkg::LTIC_OP_LOAD, 1'b1, 1'b0);
    chk("ifetch alloc", allocEn, 1'b0);
    acc(ltic_pkg::LTIC_OP_FLUSH, 1'b0, 1'b1);
    chk("push", {flushToCache, l1Invalidate}, 2'b11);
    xlateOn  <= 1'b1;
    pageAttr <= 4'h0;
    acc(ltic_pkg::LTIC_OP_LOAD, 1'b0, 1'b0);
    chk("xlate lookup", lookupEn, 1'b1);
    accValid <= 1'b0;
    end_sim();
  end
endmodule
